// ===== dv/test_adcsr_top.sv
// self-checking bench for the converter status and control register block
`timescale 1ns/100ps
`include "adcsr_cfg.svh"

module test_adcsr_top;
	typedef struct {string nm; logic [31:0] v;} adcsr_note_t;
	logic I_CLK, I_NRST, I_CE, I_HSEL, I_HWRITE, I_IS_SECOND, I_TRIG, I_ADC_TICK;
	logic I_CONV_START, I_CONV_DONE, I_CHAN_DONE, I_CONV_VALID, I_RESULT_READ, I_PEER_IRQ;
	logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, d;
	logic [1:0] I_HTRANS;
	logic [2:0] I_HSIZE;
	logic [11:0] I_CONV_DATA, I_WD_LOW, I_WD_HIGH;
	logic [4:0] I_CONV_CHAN, O_WD_CHAN;
	logic [3:0] O_SYNC_MODE, O_DISC_REMAIN;
	logic O_HREADYOUT, O_HRESP, O_START_FIRST, O_START_SECOND, O_RWD_EN, O_DISC_EN;
	logic O_GROUP_DONE, O_SCAN_EN, O_WD_SINGLE, O_IRQ_OWN, O_IRQ, rd_pend;
	logic [3:0] modes [4] = '{4'h0, 4'h6, 4'h7, 4'h8};
	logic [31:0] wc [8] = '{32'h40, 32'h800040, 32'h800000, 32'h800040,
		32'h800040, 32'h800365, 32'h800365, 32'h800164};
	logic [11:0] wd [8] = '{12'h250, 12'h100, 12'h0ff, 12'h201, 12'h200, 12'h300, 12'h300, 12'h300};
	logic [4:0] wch [8] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h4, 5'h5, 5'h4};
	logic we [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
	adcsr_note_t notes [$];
	adcsr_note_t note;
	int qf [$];
	int qs [$];
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int t;

	adcsr_top u_adcsr_top (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_HSEL(I_HSEL),
		.I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE),
		.I_HREADY(O_HREADYOUT), .I_HWDATA(I_HWDATA), .O_HRDATA(O_HRDATA),
		.O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_IS_SECOND(I_IS_SECOND),
		.I_TRIG(I_TRIG), .I_ADC_TICK(I_ADC_TICK), .I_CONV_START(I_CONV_START),
		.I_CONV_DONE(I_CONV_DONE), .I_CHAN_DONE(I_CHAN_DONE), .I_CONV_VALID(I_CONV_VALID),
		.I_CONV_DATA(I_CONV_DATA), .I_CONV_CHAN(I_CONV_CHAN), .I_WD_LOW(I_WD_LOW),
		.I_WD_HIGH(I_WD_HIGH), .I_RESULT_READ(I_RESULT_READ), .I_PEER_IRQ(I_PEER_IRQ),
		.O_START_FIRST(O_START_FIRST), .O_START_SECOND(O_START_SECOND),
		.O_SYNC_MODE(O_SYNC_MODE), .O_RWD_EN(O_RWD_EN), .O_DISC_EN(O_DISC_EN),
		.O_DISC_REMAIN(O_DISC_REMAIN), .O_GROUP_DONE(O_GROUP_DONE), .O_SCAN_EN(O_SCAN_EN),
		.O_WD_SINGLE(O_WD_SINGLE), .O_WD_CHAN(O_WD_CHAN), .O_IRQ_OWN(O_IRQ_OWN), .O_IRQ(O_IRQ));

	always #5 I_CLK = ~I_CLK;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	// address phase held until ready, then released to idle
	task automatic addr_ph(input logic [31:0] a, input logic w);
		@(posedge I_CLK);
		I_HSEL <= 1'b1;
		I_HTRANS <= `ADCSR_HTRANS_NONSEQ;
		I_HSIZE <= `ADCSR_HSIZE_WORD;
		I_HADDR <= a;
		I_HWRITE <= w;
		do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
		I_HTRANS <= 2'h0;
		I_HSEL <= 1'b0;
	endtask : addr_ph

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		addr_ph(a, 1'b1);
		I_HWDATA <= v;
		do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
	endtask : wr

	// the monitor takes the read data at the closing edge of the data phase
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
		notes.push_back(adcsr_note_t'{nm, e});
		addr_ph(a, 1'b0);
		do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
	endtask : rd

	// one-cycle event pulse: {trig, chan_done, valid, result_read, done, start}
	task automatic ev(input logic [5:0] s, input logic [11:0] v, input logic [4:0] c);
		@(posedge I_CLK);
		{I_TRIG, I_CHAN_DONE, I_CONV_VALID, I_RESULT_READ, I_CONV_DONE, I_CONV_START} <= s;
		I_CONV_DATA <= v;
		I_CONV_CHAN <= c;
		@(posedge I_CLK);
		{I_TRIG, I_CHAN_DONE, I_CONV_VALID, I_RESULT_READ, I_CONV_DONE, I_CONV_START} <= 6'h0;
		if (s[5]) qf.push_back(cyc + 1);
	endtask : ev

	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		if (rd_pend && notes.size() > 0) begin
			note = notes.pop_front();
			chk(note.nm, note.v, O_HRDATA);
			chk("response", 32'h0, {31'h0, O_HRESP});
		end
		rd_pend <= I_NRST && I_CE && I_HSEL && I_HTRANS === 2'h2 && I_HWRITE === 1'b0;
		if (O_START_FIRST === 1'b1) chk("first start edge", qf.size() ? qf.pop_front() : 0, cyc);
		if (O_START_SECOND === 1'b1) chk("second start edge", qs.size() ? qs.pop_front() : 0, cyc);
	end

	initial begin
		repeat (20000) @(posedge I_CLK);
		err_total++;
		summarize();
	end

	initial begin
		I_CLK = 1'b0;
		I_NRST = 1'b0;
		I_CE = 1'b1;
		{I_HSEL, I_HWRITE, I_IS_SECOND, I_TRIG, I_ADC_TICK, I_PEER_IRQ, rd_pend} = 7'h0;
		{I_CONV_START, I_CONV_DONE, I_CHAN_DONE, I_CONV_VALID, I_RESULT_READ} = 5'h0;
		{I_HADDR, I_HWDATA, I_HTRANS, I_HSIZE, I_CONV_DATA, I_CONV_CHAN} = '0;
		I_WD_LOW = 12'h100;
		I_WD_HIGH = 12'h200;
		d = $urandom(32'h9710);
		repeat (10) @(posedge I_CLK);
		I_NRST <= 1'b1;
		I_CE <= 1'b0;
		// a clock-enable stall holds the read off until the enable returns
		fork
			rd(`ADCSR_OFF_STATUS, `ADCSR_STATUS_RST, "status reset");
			begin
				repeat (3) @(posedge I_CLK);
				I_CE <= 1'b1;
			end
		join
		rd(`ADCSR_OFF_CTRL, `ADCSR_CTRL_RST, "control reset");
		wr(32'h08, 32'hffffffff);
		rd(32'h08, 32'h0, "unmapped");
		wr(`ADCSR_OFF_CTRL, 32'hfff8ffff);
		rd(`ADCSR_OFF_CTRL, `ADCSR_CTRL_MASK & 32'hfff8ffff, "control mask");
		wr(`ADCSR_OFF_CTRL, 32'h0);
		for (int i = 0; i < 8; i++) begin
			d = $urandom();
			d[19:16] = modes[i % 4];
			d[4:0] = 5'(2 * i + 3);
			I_IS_SECOND <= i[0];
			wr(`ADCSR_OFF_CTRL, d);
			@(negedge I_CLK);
			chk("sync mode", i[0] ? 32'h0 : {28'h0, d[19:16]}, {28'h0, O_SYNC_MODE});
			chk("rwd disc scan single", {d[23], d[11], d[8], d[9]}, {O_RWD_EN, O_DISC_EN, O_SCAN_EN, O_WD_SINGLE});
			chk("watchdog channel", {27'h0, d[4:0]}, {27'h0, O_WD_CHAN});
			// the second instance must start alone even with a sync code stored
			if (i[0]) ev(6'h20, 12'h0, 5'h0);
			rd(`ADCSR_OFF_CTRL, d & `ADCSR_CTRL_MASK, "control random");
			wr(`ADCSR_OFF_CTRL, 32'h0);
		end
		I_IS_SECOND <= 1'b0;
		ev(6'h03, 12'h0, 5'h0);
		rd(`ADCSR_OFF_STATUS, 32'h12, "start and done");
		wr(`ADCSR_OFF_STATUS, 32'h13);
		rd(`ADCSR_OFF_STATUS, 32'h12, "write ones");
		wr(`ADCSR_OFF_STATUS, 32'h10);
		rd(`ADCSR_OFF_STATUS, 32'h10, "done cleared");
		wr(`ADCSR_OFF_STATUS, 32'h0);
		rd(`ADCSR_OFF_STATUS, 32'h0, "start cleared");
		ev(6'h02, 12'h0, 5'h0);
		@(negedge I_CLK);
		chk("irq masked", 32'h0, {O_IRQ, O_IRQ_OWN});
		@(posedge I_CLK);
		I_PEER_IRQ <= 1'b1;
		@(negedge I_CLK);
		chk("peer irq", 32'h2, {O_IRQ, O_IRQ_OWN});
		@(posedge I_CLK);
		I_PEER_IRQ <= 1'b0;
		wr(`ADCSR_OFF_CTRL, 32'h20);
		@(negedge I_CLK);
		chk("done irq", 32'h3, {O_IRQ, O_IRQ_OWN});
		ev(6'h04, 12'h0, 5'h0);
		@(negedge I_CLK);
		chk("result read", 32'h0, {O_IRQ, O_IRQ_OWN});
		// band edges, watchdog off, scan with single or all channels
		for (int i = 0; i < 8; i++) begin
			wr(`ADCSR_OFF_CTRL, wc[i]);
			ev(6'h08, wd[i], wch[i]);
			wr(`ADCSR_OFF_STATUS, 32'h1);
			rd(`ADCSR_OFF_STATUS, {31'h0, we[i]}, "watchdog flag");
			chk("watchdog irq", {31'h0, we[i] & wc[i][6]}, {31'h0, O_IRQ_OWN});
			wr(`ADCSR_OFF_STATUS, 32'h0);
		end
		for (int l = 0; l < 8; l += 7) begin
			wr(`ADCSR_OFF_CTRL, 32'h800 | (l << 13));
			ev(6'h20, 12'h0, 5'h0);
			@(negedge I_CLK);
			chk("group reload", l + 1, {28'h0, O_DISC_REMAIN});
			for (int k = 0; k <= l; k++) ev(6'h10, 12'h0, 5'h0);
			@(negedge I_CLK);
			chk("group end", 32'h10, {O_GROUP_DONE, O_DISC_REMAIN});
		end
		for (int m = 0; m < 4; m++) begin
			wr(`ADCSR_OFF_CTRL, {12'h0, modes[m], 16'h0});
			@(posedge I_CLK);
			I_TRIG <= 1'b1;
			t = cyc + 1;
			if (m < 2) qf.push_back(t + 1);
			if (m > 0) qs.push_back(t + 1);
			if (m == 2) qf.push_back(t + 22);
			if (m == 3) qf.push_back(t + 43);
			if (m == 3) qs.push_back(t + 85);
			// ticks every third edge; a second trigger in slow mode must be dropped
			for (int k = 0; k < 90; k++) begin
				@(posedge I_CLK);
				I_TRIG <= (m == 3 && cyc + 1 == t + 10);
				I_ADC_TICK <= ((cyc + 1 - t) % 3 == 0);
			end
			I_ADC_TICK <= 1'b0;
			chk("starts outstanding", 32'h0, qf.size() + qs.size());
		end
		wr(`ADCSR_OFF_CTRL, 32'h0);
		repeat (3) @(posedge I_CLK);
		summarize();
	end
endmodule : test_adcsr_top

// ===== hw/adcsr_ahb_slave.sv
// zero-wait AHB-Lite slave front end for the register block
`timescale 1ns/100ps
`include "adcsr_cfg.svh"

module adcsr_ahb_slave
	import adcsr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic i_hready,
	input wire logic [31:0] i_hwdata,
	input wire logic [31:0] i_rd_value,
	output logic [7:0] o_rd_addr,
	output logic o_wr_en,
	output logic [7:0] o_wr_addr,
	output logic [31:0] o_wr_data,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp
);

	adcsr_bus_state_t s_q;
	adcsr_bus_state_t s_d;
	logic accept;

	// non-word transfers are taken but act as no-ops
	assign accept = i_hsel && (i_htrans == `ADCSR_HTRANS_NONSEQ) && i_hready
		&& (i_hsize == `ADCSR_HSIZE_WORD);

	always_comb begin
		s_d = s_q;
		s_d.dphase = accept;
		s_d.dwrite = accept && i_hwrite;
		s_d.daddr = i_haddr[7:0];
		s_d.rdata = (accept && !i_hwrite) ? i_rd_value : 32'h0000_0000;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	assign o_rd_addr = i_haddr[7:0];
	assign o_wr_en = s_q.dwrite;
	assign o_wr_addr = s_q.daddr;
	assign o_wr_data = i_hwdata;
	assign o_hrdata = s_q.rdata;
	// a low clock enable stalls the bus rather than losing a transfer
	assign o_hreadyout = i_ce;
	assign o_hresp = 1'b0;

endmodule : adcsr_ahb_slave

// ===== hw/adcsr_cfg.svh
// constants for the converter status and control register block
`ifndef ADCSR_CFG_SVH
`define ADCSR_CFG_SVH

// register byte offsets
`define ADCSR_OFF_STATUS 8'h00
`define ADCSR_OFF_CTRL 8'h04

// status bit positions and reset value
`define ADCSR_ST_START_BIT 4
`define ADCSR_ST_DONE_BIT 1
`define ADCSR_ST_WD_BIT 0
`define ADCSR_STATUS_RST 32'h0000_0000

// control bit positions
`define ADCSR_CT_RWD_BIT 23
`define ADCSR_CT_SYNC_MSB 19
`define ADCSR_CT_SYNC_LSB 16
`define ADCSR_CT_DLEN_MSB 15
`define ADCSR_CT_DLEN_LSB 13
`define ADCSR_CT_DISC_BIT 11
`define ADCSR_CT_WATCHDOG_SINGLE_CHANNEL_BIT 9
`define ADCSR_CT_SCAN_BIT 8
`define ADCSR_CT_WDIE_BIT 6
`define ADCSR_CT_DONEIE_BIT 5
`define ADCSR_CT_CHAN_MSB 4
`define ADCSR_CT_CHAN_LSB 0
`define ADCSR_CTRL_MASK 32'h008f_eb7f
`define ADCSR_CTRL_RST 32'h0000_0000

// sync mode codes
`define ADCSR_SYNC_FREE 4'h0
`define ADCSR_SYNC_PAR 4'h6
`define ADCSR_SYNC_FAST 4'h7
`define ADCSR_SYNC_SLOW 4'h8

// follow-up delays in converter clock ticks
`define ADCSR_FAST_DLY 5'h07
`define ADCSR_SLOW_DLY 5'h0e

// highest legal watchdog channel
`define ADCSR_CHAN_MAX 5'h11

// bus encodings
`define ADCSR_HTRANS_NONSEQ 2'h2
`define ADCSR_HSIZE_WORD 3'h2

`endif

// ===== hw/adcsr_pkg.sv
// types for the converter status and control register block
package adcsr_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT_FIRST,
		SEQ_WAIT_SECOND
	} adcsr_seq_st_t;

	typedef struct packed {
		adcsr_seq_st_t st;
		logic [4:0] cnt;
		logic slow;
		logic start_first;
		logic start_second;
	} adcsr_seq_state_t;

	typedef struct packed {
		logic dphase;
		logic dwrite;
		logic [7:0] daddr;
		logic [31:0] rdata;
	} adcsr_bus_state_t;

	typedef struct packed {
		logic st_start;
		logic st_done;
		logic st_wd;
		logic [31:0] ctrl;
		logic [3:0] remain;
		logic group_done;
	} adcsr_top_state_t;

endpackage : adcsr_pkg

// ===== hw/adcsr_sync_seq.sv
// start sequencer for the dual-converter sync modes
`timescale 1ns/100ps
`include "adcsr_cfg.svh"

module adcsr_sync_seq
	import adcsr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_trig,
	input wire logic i_tick,
	input wire logic [3:0] i_mode,
	output logic o_busy,
	output logic o_start_first,
	output logic o_start_second
);

	adcsr_seq_state_t s_q;
	adcsr_seq_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.start_first = 1'b0;
		s_d.start_second = 1'b0;
		unique case (s_q.st)
			SEQ_IDLE: begin
				if (i_trig) begin
					// reserved codes fall back to independent starts
					unique case (i_mode)
						`ADCSR_SYNC_PAR: begin
							s_d.start_first = 1'b1;
							s_d.start_second = 1'b1;
						end
						`ADCSR_SYNC_FAST: begin
							s_d.start_second = 1'b1;
							s_d.cnt = `ADCSR_FAST_DLY;
							s_d.slow = 1'b0;
							s_d.st = SEQ_WAIT_FIRST;
						end
						`ADCSR_SYNC_SLOW: begin
							s_d.start_second = 1'b1;
							s_d.cnt = `ADCSR_SLOW_DLY;
							s_d.slow = 1'b1;
							s_d.st = SEQ_WAIT_FIRST;
						end
						default: begin
							s_d.start_first = 1'b1;
						end
					endcase
				end
			end
			SEQ_WAIT_FIRST: begin
				if (i_tick) begin
					if (s_q.cnt == 5'h01) begin
						s_d.start_first = 1'b1;
						if (s_q.slow) begin
							s_d.cnt = `ADCSR_SLOW_DLY;
							s_d.st = SEQ_WAIT_SECOND;
						end else begin
							s_d.st = SEQ_IDLE;
						end
					end else begin
						s_d.cnt = s_q.cnt - 5'h01;
					end
				end
			end
			SEQ_WAIT_SECOND: begin
				if (i_tick) begin
					if (s_q.cnt == 5'h01) begin
						s_d.start_second = 1'b1;
						s_d.st = SEQ_IDLE;
					end else begin
						s_d.cnt = s_q.cnt - 5'h01;
					end
				end
			end
			default: begin
				s_d.st = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	// triggers while a follow-up sequence runs are dropped
	assign o_busy = (s_q.st != SEQ_IDLE);
	assign o_start_first = s_q.start_first;
	assign o_start_second = s_q.start_second;

endmodule : adcsr_sync_seq

// ===== hw/adcsr_top.sv
// converter status and first control register block with AHB-Lite access
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "adcsr_cfg.svh"

module adcsr_top
	import adcsr_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_CE,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic I_HREADY,
	input wire logic [31:0] I_HWDATA,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire logic I_IS_SECOND,
	input wire logic I_TRIG,
	input wire logic I_ADC_TICK,
	input wire logic I_CONV_START,
	input wire logic I_CONV_DONE,
	input wire logic I_CHAN_DONE,
	input wire logic I_CONV_VALID,
	input wire logic [11:0] I_CONV_DATA,
	input wire logic [4:0] I_CONV_CHAN,
	input wire logic [11:0] I_WD_LOW,
	input wire logic [11:0] I_WD_HIGH,
	input wire logic I_RESULT_READ,
	input wire logic I_PEER_IRQ,
	output logic O_START_FIRST,
	output logic O_START_SECOND,
	output logic [3:0] O_SYNC_MODE,
	output logic O_RWD_EN,
	output logic O_DISC_EN,
	output logic [3:0] O_DISC_REMAIN,
	output logic O_GROUP_DONE,
	output logic O_SCAN_EN,
	output logic O_WD_SINGLE,
	output logic [4:0] O_WD_CHAN,
	output logic O_IRQ_OWN,
	output logic O_IRQ
);

	adcsr_top_state_t s_q;
	adcsr_top_state_t s_d;
	logic [7:0] rd_addr;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] rd_value;
	logic [31:0] status_word;
	logic wr_status;
	logic wr_ctrl;
	logic rwd_en;
	logic disc_en;
	logic scan_en;
	logic wd_single;
	logic done_ie;
	logic wd_ie;
	logic [3:0] sync_field;
	logic [3:0] sync_eff;
	logic [2:0] group_len;
	logic [4:0] wd_chan;
	logic wd_out_of_band;
	logic wd_chan_match;
	logic wd_hit;
	logic seq_busy;
	logic seq_first;
	logic seq_second;

	adcsr_ahb_slave u_bus (
		.i_clk(I_CLK),
		.i_nrst(I_NRST),
		.i_ce(I_CE),
		.i_hsel(I_HSEL),
		.i_haddr(I_HADDR),
		.i_htrans(I_HTRANS),
		.i_hwrite(I_HWRITE),
		.i_hsize(I_HSIZE),
		.i_hready(I_HREADY),
		.i_hwdata(I_HWDATA),
		.i_rd_value(rd_value),
		.o_rd_addr(rd_addr),
		.o_wr_en(wr_en),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.o_hrdata(O_HRDATA),
		.o_hreadyout(O_HREADYOUT),
		.o_hresp(O_HRESP)
	);

	// control field decode
	assign rwd_en = s_q.ctrl[`ADCSR_CT_RWD_BIT];
	assign sync_field = s_q.ctrl[`ADCSR_CT_SYNC_MSB:`ADCSR_CT_SYNC_LSB];
	assign group_len = s_q.ctrl[`ADCSR_CT_DLEN_MSB:`ADCSR_CT_DLEN_LSB];
	assign disc_en = s_q.ctrl[`ADCSR_CT_DISC_BIT];
	assign wd_single = s_q.ctrl[`ADCSR_CT_WATCHDOG_SINGLE_CHANNEL_BIT];
	assign scan_en = s_q.ctrl[`ADCSR_CT_SCAN_BIT];
	assign wd_ie = s_q.ctrl[`ADCSR_CT_WDIE_BIT];
	assign done_ie = s_q.ctrl[`ADCSR_CT_DONEIE_BIT];
	assign wd_chan = s_q.ctrl[`ADCSR_CT_CHAN_MSB:`ADCSR_CT_CHAN_LSB];

	// the second instance keeps its field readable but never acts on it
	assign sync_eff = I_IS_SECOND ? `ADCSR_SYNC_FREE : sync_field;

	adcsr_sync_seq u_seq (
		.i_clk(I_CLK),
		.i_nrst(I_NRST),
		.i_ce(I_CE),
		.i_trig(I_TRIG),
		.i_tick(I_ADC_TICK),
		.i_mode(sync_eff),
		.o_busy(seq_busy),
		.o_start_first(seq_first),
		.o_start_second(seq_second)
	);

	// watchdog compare on each converted value
	assign wd_out_of_band = (I_CONV_DATA < I_WD_LOW) || (I_CONV_DATA > I_WD_HIGH);
	// reserved channel codes never match, so in scan single-channel mode they never raise the flag
	assign wd_chan_match = (I_CONV_CHAN == wd_chan) && (wd_chan <= `ADCSR_CHAN_MAX);
	assign wd_hit = rwd_en && I_CONV_VALID && wd_out_of_band
		&& (!(scan_en && wd_single) || wd_chan_match);

	assign wr_status = wr_en && (wr_addr == `ADCSR_OFF_STATUS);
	assign wr_ctrl = wr_en && (wr_addr == `ADCSR_OFF_CTRL);

	always_comb begin
		status_word = `ADCSR_STATUS_RST;
		status_word[`ADCSR_ST_START_BIT] = s_q.st_start;
		status_word[`ADCSR_ST_DONE_BIT] = s_q.st_done;
		status_word[`ADCSR_ST_WD_BIT] = s_q.st_wd;
	end

	always_comb begin
		unique case (rd_addr)
			`ADCSR_OFF_STATUS: rd_value = status_word;
			`ADCSR_OFF_CTRL: rd_value = s_q.ctrl;
			default: rd_value = 32'h0000_0000;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.group_done = 1'b0;
		// in each flag the hardware set is applied last so it wins a clash
		if (wr_status && !wr_data[`ADCSR_ST_START_BIT]) begin
			s_d.st_start = 1'b0;
		end
		if (I_CONV_START) begin
			s_d.st_start = 1'b1;
		end
		if ((wr_status && !wr_data[`ADCSR_ST_DONE_BIT]) || I_RESULT_READ) begin
			s_d.st_done = 1'b0;
		end
		if (I_CONV_DONE) begin
			s_d.st_done = 1'b1;
		end
		if (wr_status && !wr_data[`ADCSR_ST_WD_BIT]) begin
			s_d.st_wd = 1'b0;
		end
		if (wd_hit) begin
			s_d.st_wd = 1'b1;
		end
		if (wr_ctrl) begin
			s_d.ctrl = wr_data & `ADCSR_CTRL_MASK;
		end
		// discontinuous group counter, reloaded by every trigger while discontinuous mode is enabled
		if (I_TRIG && disc_en) begin
			s_d.remain = {1'b0, group_len} + 4'h1;
		end else if (I_CHAN_DONE && (s_q.remain != 4'h0)) begin
			s_d.remain = s_q.remain - 4'h1;
			s_d.group_done = (s_q.remain == 4'h1);
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			s_q <= '0;
		end else if (I_CE) begin
			s_q <= s_d;
		end
	end

	assign O_START_FIRST = seq_first;
	assign O_START_SECOND = seq_second;
	assign O_SYNC_MODE = sync_eff;
	assign O_RWD_EN = rwd_en;
	assign O_DISC_EN = disc_en;
	assign O_DISC_REMAIN = s_q.remain;
	assign O_GROUP_DONE = s_q.group_done;
	assign O_SCAN_EN = scan_en;
	assign O_WD_SINGLE = wd_single;
	assign O_WD_CHAN = wd_chan;
	// the start flag has no enable and so never requests an interrupt
	assign O_IRQ_OWN = (s_q.st_done && done_ie) || (s_q.st_wd && wd_ie);
	assign O_IRQ = O_IRQ_OWN || I_PEER_IRQ;

	// helper: converter ticks counted while the sequencer is busy since the last accepted trigger
	logic [5:0] help_cnt_q;
	logic [3:0] help_mode_q;

	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			help_cnt_q <= 6'h00;
			help_mode_q <= 4'h0;
		end else if (I_CE) begin
			if (I_TRIG && !seq_busy) begin
				help_cnt_q <= 6'h00;
				help_mode_q <= sync_eff;
			end else if (I_ADC_TICK && seq_busy) begin
				help_cnt_q <= help_cnt_q + 6'h01;
			end
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	property p_start_set;
		I_CE && I_CONV_START |=> s_q.st_start;
	endproperty
	a_start_set: assert property (p_start_set) else $error("start flag not set");

	property p_start_hold;
		I_CE && s_q.st_start && !(wr_status && !wr_data[`ADCSR_ST_START_BIT]) |=> s_q.st_start;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start flag lost");

	property p_done_set;
		I_CE && I_CONV_DONE |=> s_q.st_done && (!done_ie || O_IRQ_OWN);
	endproperty
	a_done_set: assert property (p_done_set) else $error("end flag not set");

	property p_done_rd_clr;
		I_CE && I_RESULT_READ && !I_CONV_DONE |=> !s_q.st_done;
	endproperty
	a_done_rd_clr: assert property (p_done_rd_clr) else $error("end flag kept after read");

	property p_wd_set;
		I_CE && wd_hit |=> s_q.st_wd;
	endproperty
	a_wd_set: assert property (p_wd_set) else $error("watchdog flag not set");

	property p_wd_write1;
		I_CE && s_q.st_wd && wr_status && wr_data[`ADCSR_ST_WD_BIT] |=> s_q.st_wd;
	endproperty
	a_wd_write1: assert property (p_wd_write1) else $error("watchdog flag cleared by one");

	property p_wd_off;
		// checks the flag itself, so a broken enable gate in the hit term is caught
		!rwd_en && !s_q.st_wd |=> !s_q.st_wd;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("watchdog hit while disabled");

	property p_disc_load;
		I_CE && I_TRIG && disc_en |=> O_DISC_REMAIN == ({1'b0, $past(group_len)} + 4'h1);
	endproperty
	a_disc_load: assert property (p_disc_load) else $error("group length wrong");

	property p_second_free;
		I_CE && I_IS_SECOND && I_TRIG && !seq_busy |=> O_START_FIRST && !O_START_SECOND;
	endproperty
	a_second_free: assert property (p_second_free) else $error("second instance used sync");

	property p_fast_first;
		O_START_FIRST && (help_mode_q == `ADCSR_SYNC_FAST) |-> help_cnt_q == 6'(`ADCSR_FAST_DLY);
	endproperty
	a_fast_first: assert property (p_fast_first) else $error("fast first start mistimed");

	property p_slow_second;
		O_START_SECOND && (help_mode_q == `ADCSR_SYNC_SLOW) && (help_cnt_q != 6'h00)
			|-> help_cnt_q == 6'(`ADCSR_SLOW_DLY) + 6'(`ADCSR_SLOW_DLY);
	endproperty
	a_slow_second: assert property (p_slow_second) else $error("slow second restart mistimed");

	property p_irq_done;
		s_q.st_done && done_ie |-> O_IRQ && O_IRQ_OWN;
	endproperty
	a_irq_done: assert property (p_irq_done) else $error("end interrupt missing");

	property p_irq_masked;
		!wd_ie && !(s_q.st_done && done_ie) |-> !O_IRQ_OWN;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");

	property p_irq_peer;
		I_PEER_IRQ |-> O_IRQ;
	endproperty
	a_irq_peer: assert property (p_irq_peer) else $error("peer interrupt not merged");

	property p_c_fast;
		O_START_FIRST && (help_mode_q == `ADCSR_SYNC_FAST);
	endproperty
	c_fast: cover property (p_c_fast);

	property p_c_slow;
		O_START_SECOND && (help_mode_q == `ADCSR_SYNC_SLOW) && (help_cnt_q != 6'h00);
	endproperty
	c_slow: cover property (p_c_slow);

	property p_c_wd_irq;
		s_q.st_wd && wd_ie && O_IRQ_OWN;
	endproperty
	c_wd_irq: cover property (p_c_wd_irq);

	property p_c_group;
		O_GROUP_DONE;
	endproperty
	c_group: cover property (p_c_group);

endmodule : adcsr_top
